// [softstart_fault_sequencer_cfg.svh]
`ifndef SOFTSTART_FAULT_SEQUENCER_CFG_SVH
`define SOFTSTART_FAULT_SEQUENCER_CFG_SVH

// ==========================================================
// Register map (byte addresses)
`define REG_REF_TARGET      4'h0
`define REG_SW_DIVIDER      4'h4
`define REG_STATUS          4'h8
`define REG_REF_NOW         4'hC

// ==========================================================
// Reset values and field layout
`define REF_TARGET_RESET    16'h0600
`define REF_STEPS_PER_VOLT  1280
`define STATUS_STATE_LSB    0
`define STATUS_SUPPLY_OK    4
`define STATUS_OV           5
`define STATUS_UV           6
`define STATUS_DRIVE_EN     7
`define STATUS_SS_DONE      8

// ==========================================================
// Timing
`define CLK_FREQ_KHZ        20000
`define SW_FREQ_KHZ         450
`define SW_DIV_RESET        (`CLK_FREQ_KHZ / `SW_FREQ_KHZ)
`define SS_DELAY_CYCLES     64
`define OFFSET_RAMP_CYCLES  640
`define OC_WAIT_CYCLES      4096
`endif

// [softstart_fault_sequencer_pkg.sv]
package softstart_fault_sequencer_pkg;

    typedef enum logic [2:0] {
        ST_SHUTDOWN,
        ST_DELAY,
        ST_RAMP,
        ST_RUN,
        ST_OC_WAIT,
        ST_OPEN_SHUT
    } seq_state_e;

    // Comparator and detect results from the analog side
    typedef struct packed {
        logic level_enable_in;
        logic bias_supply_ok;
        logic driver_supply_ok;
        logic feedback_above_ref;
        logic below_uv_trip;
        logic above_uv_release;
        logic above_ov_fixed_trip;
        logic below_ov_fixed_clear;
        logic above_ov_ref_trip;
        logic below_ov_ref_clear;
        logic open_sense;
        logic over_current;
    } cmp_s;

    // Analog control outputs
    typedef struct packed {
        logic [15:0] ref_level;
        logic [9:0]  sense_offset;
        logic        ov_trip_use_ref;
    } analog_ctl_s;

endpackage : softstart_fault_sequencer_pkg

// [softstart_fault_sequencer.sv]
`include "softstart_fault_sequencer_cfg.svh"

module softstart_fault_sequencer
    import softstart_fault_sequencer_pkg::*;
#(
    parameter int unsigned SS_DELAY = `SS_DELAY_CYCLES,
    parameter int unsigned OC_WAIT  = `OC_WAIT_CYCLES
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Analog comparator results (asynchronous)
    input  wire cmp_s        i_cmp,
    // Analog control
    output analog_ctl_s      o_analog,
    // Phase and gate control
    output logic             o_pwm_hiz,
    output logic             o_high_side_gate_en,
    output logic             o_low_side_gate_en,
    output logic             o_low_side_gate_force,
    // Status pins
    output logic             o_supply_ok_out_o,
    output logic             o_supply_ok_out_oe,
    output logic             o_overvoltage_flag_out,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ==========================================================
    // Input synchronisers
    cmp_s sync_a;
    cmp_s cmp;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync_a <= '0;
            cmp    <= '0;
        end else begin
            sync_a <= i_cmp;
            cmp    <= sync_a;
        end
    end

    // ==========================================================
    // Registers
    logic [15:0] ref_target;
    logic [15:0] sw_divider;

    // ==========================================================
    // Switching-cycle tick
    logic [15:0] div_count;
    logic        sw_tick;

    assign sw_tick = (div_count == 16'h0000);

    always_ff @(posedge i_clk) begin
        if (i_reset || sw_tick) begin
            div_count <= (sw_divider == 16'h0000) ? 16'h0000 : sw_divider - 16'h0001;
        end else begin
            div_count <= div_count - 16'h0001;
        end
    end

    // ==========================================================
    // Sequencer
    seq_state_e  state;
    seq_state_e  next_state;
    logic [12:0] cycle_count;
    logic [15:0] ref_level;
    logic [9:0]  sense_offset;
    logic        drive_en;
    logic        ss_done;
    logic        ov_active;
    logic        uv_active;

    wire  powered     = cmp.level_enable_in && cmp.bias_supply_ok && cmp.driver_supply_ok;
    wire  ramp_done   = (ref_level >= ref_target);
    wire  delay_done  = (cycle_count >= 13'(SS_DELAY - 1));
    wire  oc_done     = (cycle_count >= 13'(OC_WAIT - 1));
    wire  oc_trip     = cmp.over_current && (state == ST_RAMP || state == ST_RUN);
    wire  ov_trip     = ss_done ? cmp.above_ov_ref_trip : cmp.above_ov_fixed_trip;
    wire  ov_clear    = ss_done ? cmp.below_ov_ref_clear : cmp.below_ov_fixed_clear;
    wire  regulating  = (state == ST_RAMP || state == ST_RUN);

    always_comb begin
        next_state = state;
        case (state)
            ST_SHUTDOWN: begin
                next_state = ST_DELAY;
            end
            ST_DELAY: begin
                if (sw_tick && delay_done) begin
                    next_state = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (sw_tick && ramp_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            ST_OC_WAIT: begin
                if (sw_tick && oc_done) begin
                    next_state = ST_DELAY;
                end
            end
            ST_OPEN_SHUT: begin
                if (!cmp.open_sense) begin
                    next_state = ST_DELAY;
                end
            end
            default: begin
                next_state = ST_SHUTDOWN;
            end
        endcase
        if (oc_trip) begin
            next_state = ST_OC_WAIT;
        end
        if (cmp.open_sense && state != ST_SHUTDOWN) begin
            next_state = ST_OPEN_SHUT;
        end
        if (!powered) begin
            next_state = ST_SHUTDOWN;
        end
    end

    wire entering = (next_state != state);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= ST_SHUTDOWN;
        end else begin
            state <= next_state;
        end
    end

    // Cycle counter restarts on every state change; shared by delay and wait
    always_ff @(posedge i_clk) begin
        if (i_reset || entering) begin
            cycle_count <= 13'h0000;
        end else if (sw_tick && (state == ST_DELAY || state == ST_OC_WAIT)) begin
            cycle_count <= cycle_count + 13'h0001;
        end
    end

    // Reference ramp and sense offset, one step per switching period
    always_ff @(posedge i_clk) begin
        if (i_reset || state == ST_SHUTDOWN || state == ST_OC_WAIT || state == ST_OPEN_SHUT) begin
            ref_level    <= 16'h0000;
            sense_offset <= 10'(`OFFSET_RAMP_CYCLES);
        end else if (state == ST_DELAY) begin
            ref_level    <= 16'h0000;
            sense_offset <= 10'(`OFFSET_RAMP_CYCLES);
        end else if (state == ST_RAMP && sw_tick) begin
            if (!ramp_done) begin
                ref_level <= ref_level + 16'h0001;
            end
            if (sense_offset != 10'h000) begin
                sense_offset <= sense_offset - 10'h001;
            end
        end else if (state == ST_RUN) begin
            ref_level    <= ref_target;
            sense_offset <= 10'h000;
        end
    end

    // Drives stay off until the ramp overtakes a pre-charged output or the ramp completes
    always_ff @(posedge i_clk) begin
        if (i_reset || !regulating) begin
            drive_en <= 1'b0;
        end else if (state == ST_RAMP && !cmp.feedback_above_ref) begin
            drive_en <= 1'b1;
        end else if (state == ST_RAMP && sw_tick && ramp_done) begin
            drive_en <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset || !regulating) begin
            ss_done <= 1'b0;
        end else if (state == ST_RUN) begin
            ss_done <= 1'b1;
        end
    end

    // Overvoltage: held until the output drops below the clear level
    always_ff @(posedge i_clk) begin
        if (i_reset || !powered) begin
            ov_active <= 1'b0;
        end else if (ov_trip) begin
            ov_active <= 1'b1;
        end else if (ov_clear) begin
            ov_active <= 1'b0;
        end
    end

    // Undervoltage only affects supply-ok; hysteresis between the two levels
    always_ff @(posedge i_clk) begin
        if (i_reset || state != ST_RUN) begin
            uv_active <= 1'b0;
        end else if (cmp.below_uv_trip) begin
            uv_active <= 1'b1;
        end else if (cmp.above_uv_release) begin
            uv_active <= 1'b0;
        end
    end

    // ==========================================================
    // Outputs
    logic supply_ok_out;
    logic pwm_hiz;
    logic hs_en;
    logic ls_en;
    logic ls_force;
    logic ov_flag;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            supply_ok_out    <= 1'b0;
            pwm_hiz  <= 1'b1;
            hs_en    <= 1'b0;
            ls_en    <= 1'b0;
            ls_force <= 1'b0;
            ov_flag  <= 1'b0;
        end else begin
            supply_ok_out    <= (state == ST_RUN) && !uv_active && !ov_active;
            pwm_hiz  <= !drive_en && !ov_active;
            hs_en    <= drive_en && !ov_active;
            ls_en    <= drive_en || ov_active;
            ls_force <= ov_active;
            ov_flag  <= ov_active;
        end
    end

    assign o_supply_ok_out_o      = 1'b0;
    assign o_supply_ok_out_oe     = !supply_ok_out;
    assign o_pwm_hiz              = pwm_hiz;
    assign o_high_side_gate_en    = hs_en;
    assign o_low_side_gate_en     = ls_en;
    assign o_low_side_gate_force  = ls_force;
    assign o_overvoltage_flag_out = ov_flag;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_analog <= '0;
        end else begin
            o_analog.ref_level       <= ref_level;
            o_analog.sense_offset    <= sense_offset;
            o_analog.ov_trip_use_ref <= ss_done;
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    logic        aw_held;
    logic [3:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_ref   = do_write && (aw_addr == `REG_REF_TARGET);
    wire wr_div   = do_write && (aw_addr == `REG_SW_DIVIDER);
    wire wr_ok    = wr_ref || wr_div;

    wire [31:0] status_word = {23'h00_0000, ss_done, drive_en, uv_active, ov_active, supply_ok_out,
                               1'b0, 3'(state)};
    wire        rd_hit = (s_axi_araddr == `REG_REF_TARGET) || (s_axi_araddr == `REG_SW_DIVIDER)
                      || (s_axi_araddr == `REG_STATUS) || (s_axi_araddr == `REG_REF_NOW);
    wire [31:0] rd_word = (s_axi_araddr == `REG_REF_TARGET) ? {16'h0000, ref_target} :
                          (s_axi_araddr == `REG_SW_DIVIDER) ? {16'h0000, sw_divider} :
                          (s_axi_araddr == `REG_STATUS)     ? status_word :
                          (s_axi_araddr == `REG_REF_NOW)    ? {16'h0000, ref_level} : 32'h0000_0000;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Target changes take effect at once, even mid-ramp; a new divider loads at the next tick
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ref_target <= `REF_TARGET_RESET;
            sw_divider <= 16'(`SW_DIV_RESET);
        end else begin
            if (wr_ref && w_strb[0]) ref_target[7:0]  <= w_data[7:0];
            if (wr_ref && w_strb[1]) ref_target[15:8] <= w_data[15:8];
            if (wr_div && w_strb[0]) sw_divider[7:0]  <= w_data[7:0];
            if (wr_div && w_strb[1]) sw_divider[15:8] <= w_data[15:8];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : softstart_fault_sequencer

// [softstart_fault_sequencer_monitor.sv]
module softstart_fault_sequencer_monitor
    import softstart_fault_sequencer_pkg::*;
(
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_reset,
    // Watched ports
    input wire cmp_s        i_cmp,
    input wire analog_ctl_s o_analog,
    input wire logic        o_pwm_hiz,
    input wire logic        o_high_side_gate_en,
    input wire logic        o_low_side_gate_en,
    input wire logic        o_low_side_gate_force,
    input wire logic        o_supply_ok_out_oe,
    input wire logic        o_overvoltage_flag_out
);
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // ==========================================================
    // Inputs held past synchroniser and output latency
    sequence enable_lost;
        !i_cmp.level_enable_in [*6];
    endsequence
    sequence uv_held;
        i_cmp.below_uv_trip [*6];
    endsequence
    sequence oc_held;
        i_cmp.over_current [*6];
    endsequence

    // ==========================================================
    chk_shutdown_hiz: assert property (enable_lost |-> o_pwm_hiz)
        else $error("phase outputs driven while disabled");
    chk_disable_low: assert property (enable_lost |-> o_supply_ok_out_oe)
        else $error("supply ok released while disabled");
    chk_uv_low: assert property (uv_held |-> o_supply_ok_out_oe)
        else $error("supply ok released during undervoltage");
    chk_oc_low: assert property (oc_held |-> o_supply_ok_out_oe)
        else $error("supply ok released during overcurrent");
    chk_ov_flag_low: assert property (o_overvoltage_flag_out |-> o_supply_ok_out_oe)
        else $error("supply ok released during overvoltage");
    chk_ov_force_lo: assert property ($rose(o_overvoltage_flag_out) |-> ##[0:2] o_low_side_gate_force)
        else $error("low side not forced on overvoltage");
    chk_hiz_gates_off: assert property (o_pwm_hiz |-> !o_high_side_gate_en && !o_low_side_gate_en)
        else $error("gates enabled while phase outputs released");
    chk_ramp_step: assert property ((o_analog.ref_level > $past(o_analog.ref_level))
        |-> (o_analog.ref_level == $past(o_analog.ref_level) + 16'h0001))
        else $error("reference moved by more than one step");
    chk_offset_bound: assert property (o_analog.sense_offset <= 10'h280)
        else $error("sense offset above its start value");
    // Trip select leaves the flop one edge after supply-ok is released
    chk_trip_select: assert property (!o_supply_ok_out_oe |-> ##1 o_analog.ov_trip_use_ref)
        else $error("fixed trip in use after soft-start");
endmodule : softstart_fault_sequencer_monitor

bind softstart_fault_sequencer softstart_fault_sequencer_monitor i_monitor (
    .i_clk(i_clk), .i_reset(i_reset), .i_cmp(i_cmp), .o_analog(o_analog), .o_pwm_hiz(o_pwm_hiz),
    .o_high_side_gate_en(o_high_side_gate_en), .o_low_side_gate_en(o_low_side_gate_en),
    .o_low_side_gate_force(o_low_side_gate_force), .o_supply_ok_out_oe(o_supply_ok_out_oe),
    .o_overvoltage_flag_out(o_overvoltage_flag_out));

// [power_stage_model.sv]
module power_stage_model
    import softstart_fault_sequencer_pkg::*;
(
    // Clock and preload
    input  wire logic        i_clk,
    input  wire logic        i_load,
    input  wire logic [15:0] i_vout_init,
    // Controller side
    input  wire analog_ctl_s i_analog,
    input  wire logic        i_pwm_hiz,
    input  wire logic        i_hs_en,
    input  wire logic        i_ls_force,
    input  wire logic        i_ok_o,
    input  wire logic        i_ok_oe,
    // Sensed results
    output logic             o_fb,
    output logic             o_ok_wire
);
    logic [15:0] vout;

    // ==========================================================
    // One step per clock: a crude stand-in for the output filter
    always_ff @(posedge i_clk) begin
        if (i_load) begin
            vout <= i_vout_init;
        end else if ((i_ls_force || (!i_pwm_hiz && vout > i_analog.ref_level)) && vout != 16'h0000) begin
            vout <= vout - 16'h0001;
        end else if (i_hs_en && !i_pwm_hiz && vout < i_analog.ref_level) begin
            vout <= vout + 16'h0001;
        end
    end
    assign o_fb = vout > i_analog.ref_level;
    // Pull-up on the open-drain line
    assign o_ok_wire = (i_ok_oe && !i_ok_o) ? 1'b0 : 1'b1;
endmodule : power_stage_model

// [softstart_fault_sequencer_bench.sv]
`include "softstart_fault_sequencer_cfg.svh"
module softstart_fault_sequencer_bench
    import softstart_fault_sequencer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SS = 4;
    localparam int OCW = 8;
    localparam int TGT = 20;
    logic i_clk, i_reset, hiz, hs, ls, lf, ok_o, oe, ov, fb, okw, load;
    cmp_s cmp_drv, cmp_in, c;
    analog_ctl_s an;
    logic [15:0] vinit;
    logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [3:0] awa, ara;
    logic [31:0] wd, rdat, rd;
    logic [1:0] bresp, rresp;
    int err_total, n_compared, n;

    always_comb begin
        cmp_in = cmp_drv;
        cmp_in.feedback_above_ref = fb;
    end

    softstart_fault_sequencer #(.SS_DELAY(SS), .OC_WAIT(OCW)) i_dut (
        .i_clk(i_clk), .i_reset(i_reset), .i_cmp(cmp_in), .o_analog(an), .o_pwm_hiz(hiz),
        .o_high_side_gate_en(hs), .o_low_side_gate_en(ls), .o_low_side_gate_force(lf),
        .o_supply_ok_out_o(ok_o), .o_supply_ok_out_oe(oe), .o_overvoltage_flag_out(ov),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp));

    power_stage_model i_stage (
        .i_clk(i_clk), .i_load(load), .i_vout_init(vinit), .i_analog(an), .i_pwm_hiz(hiz), .i_hs_en(hs),
        .i_ls_force(lf), .i_ok_o(ok_o), .i_ok_oe(oe), .o_fb(fb), .o_ok_wire(okw));

    // ==========================================================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(negedge i_clk);
    endtask : tick

    task automatic setc(input cmp_s v);
        @(posedge i_clk);
        cmp_drv <= v;
    endtask : setc

    task automatic wait_ok(output int k);
        k = 0;
        while (oe !== 1'b0 && k < 400) begin
            @(negedge i_clk);
            k++;
        end
    endtask : wait_ok

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_clk);
        awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; br <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
            if (bv) break;
        end
        br <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a);
        @(posedge i_clk);
        arv <= 1'b1; ara <= a; rr <= 1'b1;
        forever begin
            @(posedge i_clk);
            if (arv && arr) arv <= 1'b0;
            if (rv) break;
        end
        rr <= 1'b0;
        rd = rdat;
    endtask : axi_rd

    task automatic report_and_stop;
        if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        report_and_stop();
    end

    // ==========================================================
    // Tests
    initial begin
        err_total = 0; n_compared = 0; i_reset = 1'b1; load = 1'b1; vinit = 16'h0000;
        awv = 0; wv = 0; br = 0; arv = 0; rr = 0; awa = 0; ara = 0; wd = 0;
        c = '0; c.above_uv_release = 1; c.below_ov_fixed_clear = 1; c.below_ov_ref_clear = 1;
        cmp_drv = c;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        axi_rd(`REG_REF_TARGET); chk("ref_target", {16'h0000, `REF_TARGET_RESET}, rd);
        chk("rresp", 32'h0000_0000, {30'h0, rresp});
        axi_rd(`REG_SW_DIVIDER); chk("sw_divider", 32'(`SW_DIV_RESET), rd);
        axi_rd(`REG_STATUS); chk("status_off", 32'h0000_0000, rd & 32'h0000_001F);
        axi_wr(`REG_STATUS, 32'h0000_0001, 2'b10);
        axi_wr(`REG_SW_DIVIDER, 32'h0000_0001, 2'b00);
        // The new divider only loads at the next tick of the old count
        tick(44);
        axi_wr(`REG_REF_TARGET, 32'(TGT), 2'b00);
        c.level_enable_in = 1; c.bias_supply_ok = 1; c.driver_supply_ok = 1; setc(c);
        wait_ok(n); chk("ss_time", 1, n >= SS + TGT && n <= SS + TGT + 8);
        chk("ok_wire", 1, okw);
        axi_rd(`REG_REF_NOW); chk("ref_now", 32'(TGT), rd);
        c.below_uv_trip = 1; c.above_uv_release = 0; setc(c); tick(6);
        chk("uv_low", 1, oe);
        axi_rd(`REG_STATUS); chk("uv_state", 3, rd & 32'h0000_0007);
        c.below_uv_trip = 0; c.above_uv_release = 1; setc(c); tick(6);
        chk("uv_release", 0, oe);
        c.above_ov_fixed_trip = 1; c.below_ov_fixed_clear = 0; setc(c); tick(6);
        chk("fixed_trip_off", 0, ov);
        c.above_ov_fixed_trip = 0; c.below_ov_fixed_clear = 1;
        c.above_ov_ref_trip = 1; c.below_ov_ref_clear = 0; setc(c); tick(6);
        chk("ov_on", 3'b111, {ov, oe, lf});
        c.above_ov_ref_trip = 0; setc(c); tick(6);
        chk("ov_hyst", 3'b111, {ov, oe, lf});
        c.below_ov_ref_clear = 1; setc(c); tick(6);
        chk("ov_off", 3'b000, {ov, oe, lf});
        axi_rd(`REG_STATUS); chk("ov_state", 3, rd & 32'h0000_0007);
        c.over_current = 1; setc(c); tick(6);
        chk("oc_gates", 3'b100, {oe, hs, ls});
        c.over_current = 0; setc(c); wait_ok(n);
        chk("oc_retry", 1, n + 7 >= OCW + SS + TGT && n + 7 <= OCW + SS + TGT + 10);
        c.open_sense = 1; setc(c); tick(6);
        chk("open_shut", 2'b11, {hiz, oe});
        c.open_sense = 0; setc(c); wait_ok(n);
        chk("open_restart", 1, n >= SS + TGT && n <= SS + TGT + 8);
        c.level_enable_in = 0; setc(c); tick(6);
        chk("disabled", 2'b11, {hiz, oe});
        axi_rd(`REG_REF_NOW); chk("ref_cleared", 0, rd);
        @(posedge i_clk);
        vinit <= 16'h001E;
        tick(2);
        c.level_enable_in = 1; setc(c);
        load <= 1'b0;
        n = 0;
        while (an.ref_level !== 16'h000A && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        chk("ref_reach", 1, n < 200);
        chk("precharge_hold", 2'b10, {hiz, hs});
        wait_ok(n);
        chk("precharge_drive", 1, hs);
        report_and_stop();
    end
endmodule : softstart_fault_sequencer_bench
